// >>> core/eiw_core.sv
// external interrupt lines, pin routing and power mode sequencer
//
// Behaviour
// - sensitivity register holds four 2-bit fields, line 3 at top, line 0 lowest.
// - codes: 00 falling and low level, 01 rising, 10 falling, 11 both edges.
// - sensitivity register writes take effect only while the cpu mask bit is set.
// - a changed sensitivity code clears the pending request of that line.
// - pin select 7:6 picks port b line 0, 1 or 2 for line 3.
// - pin select 5:4 picks port b line 3 to 6 for line 2.
// - port b line 4 chosen for line 2 never wakes from halt.
// - pin select 3:2 picks port a line 4 to 7 for line 1.
// - pin select 1:0 picks port a line 0 to 3 for line 0.
// - after reset run mode, master clock at half the oscillator rate.
// - slow mode select divides the oscillator by 32 for the peripheral clock enable.
// - wait entered during slow mode keeps the reduced clock.
// - wait stops the cpu, peripherals run, interrupt mask is cleared.
// - wait lasts until interrupt or reset, then the routine is entered.
// - the core pushes flags and holds the mask set while servicing.
// - halt enters plain halt only without active-halt and auto wake.
// - wake from halt restarts oscillator and waits 256 or 4096 cycles.
// - entering halt forces the interrupt mask to zero.
// - halt stops oscillator and all internal clock enables.
// - halt with watchdog active may give a watchdog reset instead.
// - opcode 0x8e decodes as the halt instruction.
// - with pll enabled the pll clock follows after an extra start delay.
// - edge requests latch and clear when the routine is entered.
// - auto wake enable turns halt into auto-wake halt.
`timescale 1ns/1ps
module eiw_core #(
  parameter int STARTUP_LONG_CYC  = eiw_pkg::STARTUP_LONG,
  parameter int STARTUP_SHORT_CYC = eiw_pkg::STARTUP_SHORT
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // port pins
  input  wire logic [7:0]  port_a_i,
  input  wire logic [6:0]  port_b_i,
  // cpu core side
  input  wire logic        cpu_mask_i,
  input  wire logic        op_valid_i,
  input  wire logic [7:0]  op_code_i,
  input  wire logic        wfi_exec_i,
  input  wire logic        irq_taken_i,
  input  wire logic [1:0]  irq_taken_line_i,
  input  wire logic        other_irq_i,
  input  wire logic        awu_wake_i,
  output logic      [3:0]  irq_req_o,
  output logic             mask_clear_o,
  output logic             cpu_run_o,
  output logic             periph_ce_o,
  output logic             osc_on_o,
  output logic             pll_clk_en_o,
  output logic             wake_go_o,
  output logic             wdg_reset_o
);
  // ==========================================================
  // register bus
  logic [7:0]  sens_q;
  logic [7:0]  pinsel_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  status_w;
  logic        acc_w;
  logic        wr_w;
  logic        sens_wr_w;
  logic [7:0]  sens_new_w;
  eiw_pkg::eiw_state_type state_q;

  assign acc_w      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_w       = acc_w & wb_we_i & wb_sel_i[0];
  assign sens_wr_w  = wr_w & (wb_adr_i == eiw_pkg::ADDR_SENS) &
                      cpu_mask_i;
  assign sens_new_w = sens_wr_w ? wb_dat_i[7:0] : sens_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc_w;
      if (acc_w && !wb_we_i) begin
        case (wb_adr_i)
          eiw_pkg::ADDR_SENS:   wb_dat_o <= {24'h00_0000, sens_q};
          eiw_pkg::ADDR_PINSEL: wb_dat_o <= {24'h00_0000, pinsel_q};
          eiw_pkg::ADDR_CTRL:   wb_dat_o <= {24'h00_0000, ctrl_q};
          eiw_pkg::ADDR_STATUS: wb_dat_o <= {24'h00_0000, status_w};
          default:              wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sens_q <= eiw_pkg::SENS_RESET;
    end else begin
      sens_q <= sens_new_w;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pinsel_q <= eiw_pkg::PINSEL_RESET;
      ctrl_q   <= eiw_pkg::CTRL_RESET;
    end else if (wr_w) begin
      if (wb_adr_i == eiw_pkg::ADDR_PINSEL) begin
        pinsel_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == eiw_pkg::ADDR_CTRL) begin
        ctrl_q <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [14:0] pin_w;
  logic [14:0] s1_q;
  logic [14:0] s2_q;
  logic [14:0] s3_q;
  logic [14:0] pin_q;

  assign pin_w = {port_b_i, port_a_i};

  genvar g;
  generate
    for (g = 0; g < 15; g = g + 1) begin : g_sync
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          s1_q[g]  <= 1'b1;
          s2_q[g]  <= 1'b1;
          s3_q[g]  <= 1'b1;
          pin_q[g] <= 1'b1;
        end else begin
          s1_q[g] <= pin_w[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          // a change counts only once two stages agree
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // source routing, port a at 0..7, port b at 8..14
  logic [3:0] src_w;
  logic [3:0] src_q;
  logic       pb4_line2_w;

  always_comb begin
    case (pinsel_q[7:6])
      2'h0:    src_w[3] = pin_q[8];
      2'h1:    src_w[3] = pin_q[9];
      2'h2:    src_w[3] = pin_q[10];
      default: src_w[3] = 1'b1;
    endcase
    src_w[2] = pin_q[11 + 32'(pinsel_q[5:4])];
    src_w[1] = pin_q[4 + 32'(pinsel_q[3:2])];
    src_w[0] = pin_q[32'(pinsel_q[1:0])];
  end

  assign pb4_line2_w = (pinsel_q[5:4] == eiw_pkg::LINE2_PB4_SEL);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      src_q <= 4'hf;
    end else begin
      src_q <= src_w;
    end
  end

  // ==========================================================
  // per-line edge and level detection
  logic [3:0] pend_q;
  logic [3:0] req_w;
  logic [3:0] set_w;
  logic [3:0] clr_w;

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_line
      logic [1:0] code_w;
      logic       rise_w;
      logic       fall_w;
      assign code_w = sens_q[g*2 +: 2];
      assign rise_w = src_w[g] & ~src_q[g];
      assign fall_w = ~src_w[g] & src_q[g];
      always_comb begin
        case (code_w)
          eiw_pkg::SENS_FALL_LOW: set_w[g] = fall_w;
          eiw_pkg::SENS_RISE:     set_w[g] = rise_w;
          eiw_pkg::SENS_FALL:     set_w[g] = fall_w;
          default:                set_w[g] = rise_w | fall_w;
        endcase
      end
      assign clr_w[g] = (irq_taken_i && irq_taken_line_i == 2'(g)) |
                        (sens_new_w[g*2 +: 2] != code_w);
      // a new edge in the clearing cycle is kept
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          pend_q[g] <= 1'b0;
        end else begin
          pend_q[g] <= (pend_q[g] & ~clr_w[g]) | set_w[g];
        end
      end
      assign req_w[g] = pend_q[g] |
        ((code_w == eiw_pkg::SENS_FALL_LOW) & ~src_q[g]);
    end
  endgenerate

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_req_o <= 4'h0;
    end else begin
      irq_req_o <= req_w;
    end
  end

  // ==========================================================
  // clock enable divider
  logic [4:0] div_q;
  logic [4:0] div_top_w;
  logic       clk_on_w;

  assign div_top_w = ctrl_q[eiw_pkg::CTRL_SLOW_BIT] ?
                     eiw_pkg::DIV_SLOW : eiw_pkg::DIV_RUN;
  // wait keeps whichever divider is chosen
  assign clk_on_w  = (state_q == eiw_pkg::ST_RUN) ||
                     (state_q == eiw_pkg::ST_WAIT);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_q       <= 5'h00;
      periph_ce_o <= 1'b0;
    end else if (!clk_on_w) begin
      div_q       <= 5'h00;
      periph_ce_o <= 1'b0;
    end else begin
      periph_ce_o <= (div_q >= div_top_w);
      div_q       <= (div_q >= div_top_w) ? 5'h00 : div_q + 5'h01;
    end
  end

  // ==========================================================
  // power mode sequencer
  logic                      halt_op_w;
  logic                      halt_wake_w;
  logic                      wdg_trip_w;
  logic [eiw_pkg::CNT_W-1:0] cnt_q;
  logic [eiw_pkg::CNT_W-1:0] start_cnt_w;
  logic [3:0]                halt_req_w;
  logic                      halt_enter_w;
  logic                      wait_enter_w;

  localparam logic [eiw_pkg::CNT_W-1:0] PLL_CNT =
    eiw_pkg::CNT_W'(eiw_pkg::PLL_CYCLES - 1);

  assign halt_op_w  = op_valid_i &&
                      (op_code_i == eiw_pkg::OPCODE_HALT);
  assign wdg_trip_w = ctrl_q[eiw_pkg::CTRL_WDGEN_BIT] &
                      ~ctrl_q[eiw_pkg::CTRL_WDGH_BIT] &
                      ~ctrl_q[eiw_pkg::CTRL_AHALT_BIT];
  // a refused halt keeps the cpu clocked, so the run flag must not dip
  assign halt_enter_w = halt_op_w & ~wdg_trip_w &
                        (ctrl_q[eiw_pkg::CTRL_AWU_BIT] |
                         ~ctrl_q[eiw_pkg::CTRL_AHALT_BIT]);
  assign wait_enter_w = wfi_exec_i & ~halt_op_w;
  assign halt_req_w = req_w & ~(pb4_line2_w ?
                      (4'h1 << eiw_pkg::LINE2_IDX) : 4'h0);
  assign halt_wake_w = (|halt_req_w) |
    ((state_q == eiw_pkg::ST_AWHALT) & awu_wake_i);
  // short cycle counts are the safe choice for simulation
  assign start_cnt_w = ctrl_q[eiw_pkg::CTRL_LONG_BIT] ?
    eiw_pkg::CNT_W'(STARTUP_LONG_CYC - 1) :
    eiw_pkg::CNT_W'(STARTUP_SHORT_CYC - 1);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q      <= eiw_pkg::ST_RUN;
      cnt_q        <= '0;
      mask_clear_o <= 1'b0;
      wake_go_o    <= 1'b0;
      wdg_reset_o  <= 1'b0;
    end else begin
      mask_clear_o <= 1'b0;
      wake_go_o    <= 1'b0;
      wdg_reset_o  <= 1'b0;
      case (state_q)
        eiw_pkg::ST_RUN: begin
          if (halt_op_w) begin
            if (wdg_trip_w) begin
              wdg_reset_o <= 1'b1;
            end else if (ctrl_q[eiw_pkg::CTRL_AWU_BIT]) begin
              state_q      <= eiw_pkg::ST_AWHALT;
              mask_clear_o <= 1'b1;
            end else if (!ctrl_q[eiw_pkg::CTRL_AHALT_BIT]) begin
              state_q      <= eiw_pkg::ST_HALT;
              mask_clear_o <= 1'b1;
            end
          end else if (wfi_exec_i) begin
            state_q      <= eiw_pkg::ST_WAIT;
            mask_clear_o <= 1'b1;
          end
        end
        eiw_pkg::ST_WAIT: begin
          if ((|req_w) || other_irq_i) begin
            state_q   <= eiw_pkg::ST_RUN;
            wake_go_o <= 1'b1;
          end
        end
        eiw_pkg::ST_HALT, eiw_pkg::ST_AWHALT: begin
          // pending request wakes at once since the mask is clear
          if (halt_wake_w) begin
            state_q <= eiw_pkg::ST_STARTUP;
            cnt_q   <= start_cnt_w;
          end
        end
        eiw_pkg::ST_STARTUP: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (ctrl_q[eiw_pkg::CTRL_PLL_BIT]) begin
            state_q <= eiw_pkg::ST_PLL;
            cnt_q   <= PLL_CNT;
          end else begin
            state_q   <= eiw_pkg::ST_RUN;
            wake_go_o <= 1'b1;
          end
        end
        eiw_pkg::ST_PLL: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            state_q   <= eiw_pkg::ST_RUN;
            wake_go_o <= 1'b1;
          end
        end
        default: begin
          state_q <= eiw_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // clock gating outputs
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_run_o    <= 1'b1;
      osc_on_o     <= 1'b1;
      pll_clk_en_o <= 1'b0;
    end else begin
      cpu_run_o    <= (state_q == eiw_pkg::ST_RUN) & ~halt_enter_w &
                      ~wait_enter_w;
      osc_on_o     <= (state_q != eiw_pkg::ST_HALT) &&
                      (state_q != eiw_pkg::ST_AWHALT);
      pll_clk_en_o <= ctrl_q[eiw_pkg::CTRL_PLL_BIT] &
                      clk_on_w;
    end
  end

  // ==========================================================
  // status view
  logic [2:0] mode_w;

  always_comb begin
    case (state_q)
      eiw_pkg::ST_WAIT:    mode_w = eiw_pkg::MODE_WAIT;
      eiw_pkg::ST_HALT:    mode_w = eiw_pkg::MODE_HALT;
      eiw_pkg::ST_AWHALT:  mode_w = eiw_pkg::MODE_AWHALT;
      eiw_pkg::ST_STARTUP: mode_w = eiw_pkg::MODE_STARTUP;
      eiw_pkg::ST_PLL:     mode_w = eiw_pkg::MODE_PLL;
      default:             mode_w = eiw_pkg::MODE_RUN;
    endcase
  end

  assign status_w = {ctrl_q[eiw_pkg::CTRL_SLOW_BIT], mode_w, pend_q};
endmodule : eiw_core

// >>> common/eiw_pkg.sv
// package: offsets, fields, resets and timing of the wake and interrupt block
package eiw_pkg;
  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [3:0] ADDR_SENS    = 4'h0;
  localparam logic [3:0] ADDR_PINSEL  = 4'h4;
  localparam logic [3:0] ADDR_CTRL    = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hc;
  localparam logic [7:0] SENS_RESET   = 8'h00;
  localparam logic [7:0] PINSEL_RESET = 8'h0c;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  // ==========================================================
  // control register fields
  localparam int CTRL_SLOW_BIT   = 0;
  localparam int CTRL_AWU_BIT    = 1;
  localparam int CTRL_AHALT_BIT  = 2;
  localparam int CTRL_WDGH_BIT   = 3;
  localparam int CTRL_WDGEN_BIT  = 4;
  localparam int CTRL_PLL_BIT    = 5;
  localparam int CTRL_LONG_BIT   = 6;
  // ==========================================================
  // status register fields
  localparam int STAT_PEND_LSB   = 0;
  localparam int STAT_MODE_LSB   = 4;
  localparam int STAT_SLOW_BIT   = 7;
  localparam logic [2:0] MODE_RUN     = 3'h0;
  localparam logic [2:0] MODE_WAIT    = 3'h1;
  localparam logic [2:0] MODE_HALT    = 3'h2;
  localparam logic [2:0] MODE_AWHALT  = 3'h3;
  localparam logic [2:0] MODE_STARTUP = 3'h4;
  localparam logic [2:0] MODE_PLL     = 3'h5;
  // ==========================================================
  // sensitivity codes and line fields
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE     = 2'h1;
  localparam logic [1:0] SENS_FALL     = 2'h2;
  localparam logic [1:0] SENS_BOTH     = 2'h3;
  localparam int         FIELD_W       = 2;
  localparam logic [1:0] LINE2_PB4_SEL = 2'h1;
  localparam int         LINE2_IDX     = 2;
  // ==========================================================
  // clocking and timing
  localparam int         CLK_MHZ       = 250;
  localparam logic [4:0] DIV_RUN       = 5'h01;
  localparam logic [4:0] DIV_SLOW      = 5'h1f;
  localparam int         STARTUP_SHORT = 256;
  localparam int         STARTUP_LONG  = 4096;
  localparam int         PLL_START_NS  = 200;
  localparam int         PLL_CYCLES    = (PLL_START_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] OPCODE_HALT   = 8'h8e;
  localparam int         CNT_W         = 13;
  // ==========================================================
  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT,
    ST_HALT,
    ST_AWHALT,
    ST_STARTUP,
    ST_PLL
  } eiw_state_type;
endpackage : eiw_pkg

// >>> bench/eiw_pin_model.sv
// port pin model: drives the port a and port b input lines
`timescale 1ns/1ps
module eiw_pin_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] a_want_i,
  input  wire logic [6:0] b_want_i,
  output logic      [7:0] port_a_o,
  output logic      [6:0] port_b_o
);
  // ==========================================================
  // pins idle high, as with the input pull-ups; levels move on a clock edge
  initial port_a_o = 8'hff;
  initial port_b_o = 7'h7f;
  always @(posedge clock_i) begin
    port_a_o <= a_want_i;
    port_b_o <= b_want_i;
  end
endmodule : eiw_pin_model

// >>> bench/eiw_checker.sv
// checker: port-level assertions for the wake and interrupt block
`timescale 1ns/1ps
module eiw_checker #(
  parameter int STARTUP_LONG_CYC  = 4096,
  parameter int STARTUP_SHORT_CYC = 256
) (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        op_valid_i,
  input wire logic [7:0]  op_code_i,
  input wire logic        wfi_exec_i,
  input wire logic        mask_clear_o,
  input wire logic        cpu_run_o,
  input wire logic        periph_ce_o,
  input wire logic        osc_on_o,
  input wire logic        wake_go_o,
  input wire logic        wdg_reset_o
);
  // ==========================================================
  // cycles since the oscillator came back; saturates so wait wakes pass
  logic        osc_d_q;
  logic [15:0] since_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      osc_d_q <= 1'b1;
      since_q <= 16'hffff;
    end else begin
      osc_d_q <= osc_on_o;
      if (osc_on_o && !osc_d_q) since_q <= 16'h0001;
      else if (since_q != 16'hffff) since_q <= since_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  ack_on_req_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_single_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  rdata_width_a: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  wfi_entry_a: assert property (
    wfi_exec_i && cpu_run_o && !(op_valid_i && op_code_i == 8'h8e)
    |=> mask_clear_o && !cpu_run_o) else $error("wait not entered");
  entry_mask_a: assert property (
    mask_clear_o |-> !cpu_run_o) else $error("mask clear while running");
  halt_stop_a: assert property (
    !osc_on_o |-> !cpu_run_o && !periph_ce_o) else $error("clock in halt");
  ce_gap_a: assert property (
    periph_ce_o |=> !periph_ce_o) else $error("enable too dense");
  wdg_stay_a: assert property (
    wdg_reset_o |-> cpu_run_o && $past(op_valid_i && op_code_i == 8'h8e))
    else $error("watchdog reset without halt");
  wake_delay_a: assert property (
    wake_go_o |-> since_q + 16'd2 >= STARTUP_SHORT_CYC)
    else $error("wake before startup delay");
  c_wait: cover property (wfi_exec_i ##1 mask_clear_o);
  c_halt: cover property ($rose(osc_on_o) ##[1:300] wake_go_o);
  c_wdg:  cover property (wdg_reset_o);
endmodule : eiw_checker
bind eiw_core eiw_checker #(
  .STARTUP_LONG_CYC (STARTUP_LONG_CYC),
  .STARTUP_SHORT_CYC(STARTUP_SHORT_CYC)
) i_eiw_checker (
  .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .op_valid_i(op_valid_i), .op_code_i(op_code_i), .wfi_exec_i(wfi_exec_i),
  .mask_clear_o(mask_clear_o), .cpu_run_o(cpu_run_o),
  .periph_ce_o(periph_ce_o), .osc_on_o(osc_on_o), .wake_go_o(wake_go_o),
  .wdg_reset_o(wdg_reset_o)
);

// >>> bench/ext_interrupt_wake_power_modes_tb_top.sv
// testbench top for the wake and interrupt block
`timescale 1ns/1ps
module ext_interrupt_wake_power_modes_tb_top;
  logic        clock_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mask = 1;
  logic        opv = 0, wait_for_interrupt_instruction = 0, tk = 0, oirq = 0, awu = 0;
  logic [3:0]  adr = 4'h0, sel = 4'hf, irq;
  logic [31:0] dat = 32'h0, rdat;
  logic [7:0]  op = 8'h00, pa = 8'hff, pin_a, e, v;
  logic [6:0]  pb = 7'h7f, pin_b;
  logic [1:0]  ln = 2'h0;
  logic        ack, mclr, run, ce, osc, pll, wake, wdg;
  logic [7:0]  exp_q[$];
  int          failures = 0, num_checks = 0, n;
  int          seed = 32'hd5d2f756;
  always #2 clock_i = ~clock_i;
  eiw_pin_model i_eiw_pin_model (.clock_i(clock_i), .a_want_i(pa),
    .b_want_i(pb), .port_a_o(pin_a), .port_b_o(pin_b));
  eiw_core #(.STARTUP_LONG_CYC(8), .STARTUP_SHORT_CYC(4)) i_eiw_core (
    .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .port_a_i(pin_a), .port_b_i(pin_b),
    .cpu_mask_i(mask), .op_valid_i(opv), .op_code_i(op), .wfi_exec_i(wait_for_interrupt_instruction),
    .irq_taken_i(tk), .irq_taken_line_i(ln), .other_irq_i(oirq),
    .awu_wake_i(awu), .irq_req_o(irq), .mask_clear_o(mclr),
    .cpu_run_o(run), .periph_ce_o(ce), .osc_on_o(osc),
    .pll_clk_en_o(pll), .wake_go_o(wake), .wdg_reset_o(wdg));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
    do begin @(posedge clock_i); k++; end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      failures++;
      $display("BAD bus ack expected 1 seen %b", ack);
    end
    cyc <= 0; stb <= 0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic pulse(input int s, input logic [1:0] l);
    @(posedge clock_i);
    if (s == 0) begin opv <= 1; op <= 8'h8e; end
    else if (s == 1) wait_for_interrupt_instruction <= 1;
    else begin tk <= 1; ln <= l; end
    @(posedge clock_i);
    opv <= 0; wait_for_interrupt_instruction <= 0; tk <= 0;
  endtask : pulse
  task automatic wfor(input logic s, input int lim, output int k);
    k = 0;
    while (k < lim && (s ? wdg : wake) !== 1'b1) begin
      @(posedge clock_i); k++;
    end
  endtask : wfor
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // read data are noted by the driver and compared when ack shows
  always @(posedge clock_i) if (ack === 1'b1 && we === 1'b0) begin
    e = exp_q.pop_front();
    chk("rdata", {24'h0, e}, rdat);
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 0;
    repeat (6) @(posedge clock_i);
    rd(eiw_pkg::ADDR_SENS, 8'h00);
    rd(eiw_pkg::ADDR_PINSEL, 8'h0c);
    rd(4'h1, 8'h00);
    v = 8'($random(seed));
    bus(1, eiw_pkg::ADDR_SENS, v);
    rd(eiw_pkg::ADDR_SENS, v);
    mask <= 0;
    bus(1, eiw_pkg::ADDR_SENS, ~v);
    rd(eiw_pkg::ADDR_SENS, v);
    mask <= 1;
    bus(1, eiw_pkg::ADDR_SENS, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      bus(1, eiw_pkg::ADDR_PINSEL, 8'h0c | 8'(c));
      bus(1, eiw_pkg::ADDR_SENS, 8'(c));
      pulse(2, 2'h0);
      @(posedge clock_i) pa[c] <= 1'b0;
      repeat (8) @(posedge clock_i);
      chk("fall", {31'h0, c != 1}, {31'h0, irq[0]});
      pulse(2, 2'h0);
      @(posedge clock_i) pa[c] <= 1'b1;
      repeat (8) @(posedge clock_i);
      chk("rise", 32'(c % 2), {31'h0, irq[0]});
      if (c == 3) begin
        bus(1, eiw_pkg::ADDR_SENS, 8'h02);
        repeat (2) @(posedge clock_i);
        chk("clear", 32'h0, {31'h0, irq[0]});
      end
      pulse(2, 2'h0);
    end
    $display("test sensitivity done");
    bus(1, eiw_pkg::ADDR_CTRL, 8'h01);
    pulse(1, 2'h0);
    rd(eiw_pkg::ADDR_STATUS, 8'h90);
    @(posedge clock_i) oirq <= 1;
    wfor(0, 50, n);
    chk("wait wake", 32'h1, {31'h0, n < 50});
    oirq <= 0;
    bus(1, eiw_pkg::ADDR_CTRL, 8'h10);
    pulse(0, 2'h0);
    wfor(1, 20, n);
    chk("wdg", 32'h1, {31'h0, n < 20});
    chk("run", 32'h1, {31'h0, run});
    bus(1, eiw_pkg::ADDR_CTRL, 8'h04);
    pulse(0, 2'h0);
    repeat (2) @(posedge clock_i);
    chk("run ahalt", 32'h1, {31'h0, run});
    rd(eiw_pkg::ADDR_STATUS, 8'h00);
    bus(1, eiw_pkg::ADDR_CTRL, 8'h02);
    pulse(0, 2'h0);
    rd(eiw_pkg::ADDR_STATUS, 8'h30);
    @(posedge clock_i) awu <= 1;
    wfor(0, 100, n);
    chk("awu wake", 32'h1, {31'h0, n < 100});
    awu <= 0;
    bus(1, eiw_pkg::ADDR_CTRL, 8'h00);
    $display("test wait and watchdog done");
    bus(1, eiw_pkg::ADDR_SENS, 8'h00);
    bus(1, eiw_pkg::ADDR_PINSEL, 8'h1c);
    bus(1, eiw_pkg::ADDR_SENS, 8'h22);
    pulse(0, 2'h0);
    repeat (10) @(posedge clock_i);
    chk("osc", 32'h0, {31'h0, osc});
    @(posedge clock_i) pb[4] <= 1'b0;
    wfor(0, 30, n);
    chk("pb4 wake", 32'd30, n);
    @(posedge clock_i) pa[0] <= 1'b0;
    wfor(0, 200, n);
    chk("halt wake", 32'h1, {31'h0, n >= 4 && n < 200});
    pa <= 8'hff;
    pb <= 7'h7f;
    pulse(2, 2'h0);
    $display("test halt done");
    bus(1, eiw_pkg::ADDR_CTRL, 8'h60);
    repeat (2) @(posedge clock_i);
    chk("pll on", 32'h1, {31'h0, pll});
    pulse(0, 2'h0);
    repeat (4) @(posedge clock_i);
    chk("pll off", 32'h0, {31'h0, pll});
    @(posedge clock_i) pa[0] <= 1'b0;
    wfor(0, 200, n);
    chk("pll late", 32'h1, {31'h0, n < 200});
    chk("pll wake", 32'h1, {31'h0, n >= 8 + eiw_pkg::PLL_CYCLES});
    pa <= 8'hff;
    pulse(2, 2'h0);
    $display("test pll done");
    wrap_up();
  end
endmodule : ext_interrupt_wake_power_modes_tb_top
